// >>> design/amux_pkg.sv
// constants, types and register map of the four-port aui multiplexer control block
package amux_pkg;
  localparam int NUM_PORTS = 4;
  localparam int REF_MHZ = 10;
  localparam int JAB_TIME_US = 13500;
  localparam int SQE_DELAY_NS = 1100;
  localparam int SQE_LEN_NS = 1000;
  localparam int LED_TIME_US = 1000;
  localparam int JAB_TICKS = JAB_TIME_US * REF_MHZ;
  localparam int SQE_DELAY_TICKS = SQE_DELAY_NS * REF_MHZ / 1000;
  localparam int SQE_LEN_TICKS = SQE_LEN_NS * REF_MHZ / 1000;
  localparam int LED_TICKS = LED_TIME_US * REF_MHZ;
  localparam int SQE_CNT_W = 4;
  localparam int NUM_LAMPS = 6;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h0C;
  // ctrl fields
  localparam int CTRL_SQE_OFF = 0;
  localparam int CTRL_LOOP_FORCE = 1;
  localparam int CTRL_PORT_DIS = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic [3:0] jabber;
    logic mau_col;
    logic dte_col;
  } amux_evt_type;
  typedef struct packed {
    logic [3:0] sqe;
    logic col;
    logic loop;
    logic [3:0] jabber;
    logic [3:0] sending;
  } amux_state_type;
  typedef enum logic [1:0] {
    SQE_IDLE,
    SQE_WAIT,
    SQE_PULSE
  } amux_sqe_state_type;
endpackage

// >>> design/amux_top.sv
// four-port aui multiplexer control with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module amux_top
  import amux_pkg::*;
#(
  parameter int JABBER_TICKS = JAB_TICKS,
  parameter int LAMP_TICKS = LED_TICKS,
  parameter int JAB_W = 18,
  parameter int LED_W = 14
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic osc_in,
  output logic osc_cascade_out,
  input wire logic [3:0] dte_send_pair_in,
  input wire logic [3:0] dte_send_pair_active_in,
  output logic mau_send_pair_out,
  output logic mau_send_pair_active_out,
  input wire logic mau_recv_pair_in,
  input wire logic mau_recv_pair_active_in,
  output logic [3:0] dte_recv_pair_out,
  output logic [3:0] dte_recv_pair_active_out,
  input wire logic mau_col_pair_in,
  output logic [3:0] dte_col_pair_out,
  input wire logic [3:0] quality_test_enable_n_in,
  input wire logic cascade_send_active_in,
  input wire logic cascade_col_in,
  output logic cascade_send_active_out,
  output logic cascade_col_out,
  output logic contention_lamp_n_out,
  output logic babble_lamp_port1_n_out,
  output logic babble_lamp_port2_n_out,
  output logic babble_lamp_port3_n_out,
  output logic babble_lamp_port4_n_out,
  output logic send_lamp_port1_n_out,
  output logic send_lamp_port2_n_out,
  output logic send_lamp_port3_n_out,
  output logic send_lamp_port4_n_out,
  input wire logic receive_lamp_loop_select_n_in,
  output logic receive_lamp_loop_select_n_out,
  output logic receive_lamp_loop_select_n_oe_out,
  output logic irq_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  if (JABBER_TICKS < 2 || JABBER_TICKS >= 2 ** JAB_W) begin : g_chk_jab
    $error("jabber limit does not fit its counter");
  end
  if (LAMP_TICKS < 1 || LAMP_TICKS >= 2 ** LED_W) begin : g_chk_led
    $error("lamp time does not fit its counter");
  end

  // reference clock sampling and 10 mhz tick
  logic osc_q;
  logic osc_prev_q;
  logic tick;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      osc_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      osc_q <= osc_in;
      osc_prev_q <= osc_q;
    end
  end
  assign tick = osc_q & ~osc_prev_q;
  assign osc_cascade_out = osc_q;

  // registers
  amux_evt_type status_q;
  logic [5:0] mask_q;
  logic [7:0] ctrl_q;
  amux_state_type state_w;
  amux_evt_type evt;
  logic [3:0] port_dis;
  logic sqe_off;
  logic loop_pin_q;
  logic loop;
  assign port_dis = ctrl_q[CTRL_PORT_DIS +: 4];
  assign sqe_off = ctrl_q[CTRL_SQE_OFF];
  assign loop = loop_pin_q | ctrl_q[CTRL_LOOP_FORCE];

  // per-port jabber, activity and sqe test
  logic [3:0] sending;
  logic [3:0] jab;
  logic [3:0] sqe_on;
  logic [3:0] jab_evt;
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    logic raw;
    logic [JAB_W-1:0] jcnt_q;
    logic jab_q;
    logic was_q;
    logic at_lim;
    logic sqe_go;
    amux_sqe_state_type sst_q;
    logic [SQE_CNT_W-1:0] scnt_q;
    assign raw = dte_send_pair_active_in[i] & ~port_dis[i];
    assign at_lim = jcnt_q == JAB_W'(JABBER_TICKS - 1);
    assign jab_evt[i] = raw & tick & ~jab_q & at_lim;
    assign sending[i] = raw & ~jab_q;
    assign jab[i] = jab_q;
    assign sqe_on[i] = sst_q == SQE_PULSE;
    assign sqe_go = was_q & ~raw & ~jab_q & ~quality_test_enable_n_in[i] & ~sqe_off;
    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        jcnt_q <= '0;
        jab_q <= 1'b0;
        was_q <= 1'b0;
      end else begin
        was_q <= sending[i];
        if (!raw) begin
          jcnt_q <= '0;
          jab_q <= 1'b0;
        end else if (tick && !jab_q) begin
          jcnt_q <= jcnt_q + 1'b1;
          if (at_lim) begin
            jab_q <= 1'b1;
          end
        end
      end
    end
    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        sst_q <= SQE_IDLE;
        scnt_q <= '0;
      end else begin
        unique case (sst_q)
          SQE_IDLE: begin
            scnt_q <= '0;
            if (sqe_go) begin
              sst_q <= SQE_WAIT;
            end
          end
          SQE_WAIT: begin
            if (raw) begin
              sst_q <= SQE_IDLE;
            end else if (tick) begin
              scnt_q <= scnt_q + 1'b1;
              if (scnt_q == SQE_CNT_W'(SQE_DELAY_TICKS - 1)) begin
                sst_q <= SQE_PULSE;
                scnt_q <= '0;
              end
            end
          end
          SQE_PULSE: begin
            if (jab_q) begin
              sst_q <= SQE_IDLE;
            end else if (tick) begin
              scnt_q <= scnt_q + 1'b1;
              if (scnt_q == SQE_CNT_W'(SQE_LEN_TICKS - 1)) begin
                sst_q <= SQE_IDLE;
              end
            end
          end
          default: sst_q <= SQE_IDLE;
        endcase
      end
    end
  end

  // collision detection and data paths
  logic multi;
  logic dte_col;
  logic any_col;
  logic any_send;
  logic send_bit;
  logic jam_q;
  logic dte_col_prev_q;
  logic mau_col_prev_q;
  assign multi = (sending & (sending - 4'd1)) != 4'd0;
  assign any_send = |sending;
  assign dte_col = multi | (any_send & cascade_send_active_in) | cascade_col_in;
  assign any_col = dte_col | mau_col_pair_in;
  assign send_bit = |(sending & dte_send_pair_in);
  assign cascade_send_active_out = any_send;
  assign cascade_col_out = multi | (any_send & cascade_send_active_in);
  assign evt.dte_col = dte_col & ~dte_col_prev_q;
  assign evt.mau_col = mau_col_pair_in & ~mau_col_prev_q;
  assign evt.jabber = jab_evt;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      jam_q <= 1'b0;
      dte_col_prev_q <= 1'b0;
      mau_col_prev_q <= 1'b0;
      mau_send_pair_out <= 1'b0;
      mau_send_pair_active_out <= 1'b0;
      dte_recv_pair_out <= 4'h0;
      dte_recv_pair_active_out <= 4'h0;
      dte_col_pair_out <= 4'h0;
    end else begin
      dte_col_prev_q <= dte_col;
      mau_col_prev_q <= mau_col_pair_in;
      if (tick) begin
        jam_q <= ~jam_q;
      end
      mau_send_pair_out <= dte_col ? jam_q : send_bit;
      mau_send_pair_active_out <= any_send | dte_col;
      if (loop) begin
        dte_recv_pair_out <= {4{send_bit}};
        dte_recv_pair_active_out <= {4{any_send}};
      end else begin
        dte_recv_pair_out <= {4{mau_recv_pair_in}};
        dte_recv_pair_active_out <= {4{mau_recv_pair_active_in}};
      end
      dte_col_pair_out <= {4{osc_q}} & ({4{any_col}} | jab | sqe_on);
    end
  end

  // contention, send and receive lamps with stretchers; babble lamps follow jabber directly
  logic [NUM_LAMPS-1:0] lamp_evt;
  logic [NUM_LAMPS-1:0] lamp_lit;
  assign lamp_evt = {mau_recv_pair_active_in, sending, any_col};
  for (genvar l = 0; l < NUM_LAMPS; l++) begin : g_lamp
    logic [LED_W-1:0] cnt_q;
    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        cnt_q <= '0;
      end else if (lamp_evt[l]) begin
        cnt_q <= LED_W'(LAMP_TICKS);
      end else if (tick && cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
    assign lamp_lit[l] = cnt_q != '0;
  end
  assign contention_lamp_n_out = ~lamp_lit[0];
  assign send_lamp_port1_n_out = ~lamp_lit[1];
  assign send_lamp_port2_n_out = ~lamp_lit[2];
  assign send_lamp_port3_n_out = ~lamp_lit[3];
  assign send_lamp_port4_n_out = ~lamp_lit[4];
  assign babble_lamp_port1_n_out = ~jab[0];
  assign babble_lamp_port2_n_out = ~jab[1];
  assign babble_lamp_port3_n_out = ~jab[2];
  assign babble_lamp_port4_n_out = ~jab[3];
  assign receive_lamp_loop_select_n_out = 1'b0;
  assign receive_lamp_loop_select_n_oe_out = lamp_lit[5];

  // loop strap sampled only while the lamp driver is off
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      loop_pin_q <= 1'b0;
    end else if (!lamp_lit[5]) begin
      loop_pin_q <= ~receive_lamp_loop_select_n_in;
    end
  end

  // axi4-lite write channel
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic wr_status;
  logic wr_mask;
  logic wr_ctrl;
  logic wr_ok;
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
  assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign wr_status = do_write & (awaddr_q == OFF_STATUS) & wstrb_q[0];
  assign wr_mask = do_write & (awaddr_q == OFF_MASK) & wstrb_q[0];
  assign wr_ctrl = do_write & (awaddr_q == OFF_CTRL) & wstrb_q[0];
  assign wr_ok = (awaddr_q == OFF_STATUS) | (awaddr_q == OFF_MASK)
    | (awaddr_q == OFF_CTRL) | (awaddr_q == OFF_STATE);
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // status, mask, ctrl; a new event wins over its clear
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      status_q <= '0;
      mask_q <= MASK_RST;
      ctrl_q <= CTRL_RST;
    end else begin
      status_q <= (status_q & ~(wr_status ? wdata_q[5:0] : 6'h00)) | evt;
      if (wr_mask) begin
        mask_q <= wdata_q[5:0];
      end
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[7:0];
      end
    end
  end
  assign irq_out = |(status_q & mask_q);

  // axi4-lite read channel
  logic [7:0] rd_addr;
  logic [31:0] rd_mux;
  logic rd_ok;
  assign state_w = {sqe_on, any_col, loop, jab, sending};
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};
  assign rd_ok = (rd_addr == OFF_STATUS) | (rd_addr == OFF_MASK)
    | (rd_addr == OFF_CTRL) | (rd_addr == OFF_STATE);
  assign rd_mux = (rd_addr == OFF_STATUS) ? {26'h0, status_q}
    : (rd_addr == OFF_MASK) ? {26'h0, mask_q}
    : (rd_addr == OFF_CTRL) ? {24'h0, ctrl_q}
    : (rd_addr == OFF_STATE) ? {18'h0, state_w}
    : 32'h0000_0000;
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> dv/amux_sva.sv
// pin-side assertions for the four-port aui multiplexer control
`timescale 1ns/1ps
`default_nettype none
module amux_sva
  import amux_pkg::*;
#(
  parameter int JABBER_TICKS = JAB_TICKS
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic osc_in,
  input wire logic osc_cascade_out,
  input wire logic [3:0] dte_send_pair_in,
  input wire logic [3:0] dte_send_pair_active_in,
  input wire logic mau_send_pair_out,
  input wire logic mau_col_pair_in,
  input wire logic [3:0] dte_col_pair_out,
  input wire logic [3:0] quality_test_enable_n_in,
  input wire logic cascade_send_active_in,
  input wire logic cascade_col_in,
  input wire logic cascade_col_out,
  input wire logic babble_lamp_port1_n_out,
  input wire logic send_lamp_port2_n_out
);
  localparam int JMIN = (JABBER_TICKS - 2) * 12;
  localparam int JMAX = (JABBER_TICKS + 1) * 13;
  logic [19:0] run_q;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);
  // consecutive sending cycles of port 1
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !dte_send_pair_active_in[0]) begin
      run_q <= 20'h0_0000;
    end else begin
      run_q <= run_q + 20'h0_0001;
    end
  end
  property p_osc; $rose(osc_in) |=> $rose(osc_cascade_out); endproperty
  a_osc: assert property (p_osc) else $error("cascade oscillator lost");
  property p_multi; $countones(dte_send_pair_active_in) > 1 |-> cascade_col_out; endproperty
  a_multi: assert property (p_multi) else $error("multi sender not flagged");
  property p_col; $rose(mau_col_pair_in || cascade_col_in) |-> ##[1:14] dte_col_pair_out == 4'hf;
  endproperty
  a_col: assert property (p_col) else $error("collision not forwarded");
  property p_jam; cascade_col_out && mau_send_pair_out |-> ##[1:16] !mau_send_pair_out; endproperty
  a_jam: assert property (p_jam) else $error("jam not toggling");
  property p_fwd; dte_send_pair_active_in == 4'h1 && run_q < JMIN && !cascade_send_active_in &&
    !cascade_col_in |=> mau_send_pair_out == $past(dte_send_pair_in[0]); endproperty
  a_fwd: assert property (p_fwd) else $error("transmit data not forwarded");
  property p_jab; $fell(babble_lamp_port1_n_out) |-> run_q >= JMIN && run_q <= JMAX; endproperty
  a_jab: assert property (p_jab) else $error("jabber time wrong");
  property p_unjab; !dte_send_pair_active_in[0] && !babble_lamp_port1_n_out |->
    ##[1:3] babble_lamp_port1_n_out; endproperty
  a_unjab: assert property (p_unjab) else $error("jabber not released");
  property p_sqe; $fell(dte_send_pair_active_in[0]) && run_q < JMIN && !quality_test_enable_n_in[0]
    |-> ##[120:280] dte_col_pair_out[0]; endproperty
  a_sqe: assert property (p_sqe) else $error("sqe test missing");
  property p_lamp; $rose(dte_send_pair_active_in[1]) |-> ##[1:3] !send_lamp_port2_n_out; endproperty
  a_lamp: assert property (p_lamp) else $error("send lamp not lit");
  property p_casc; cascade_send_active_in && dte_send_pair_active_in == 4'h1 |-> cascade_col_out;
  endproperty
  a_casc: assert property (p_casc) else $error("cascade overlap not flagged");
  c_multi: cover property (cascade_col_out);
  c_jab: cover property ($fell(babble_lamp_port1_n_out));
  c_sqe: cover property (dte_col_pair_out[0] && !quality_test_enable_n_in[0] && !cascade_col_out);
endmodule
bind amux_top amux_sva #(.JABBER_TICKS(JABBER_TICKS)) amux_sva_i (.clock_in, .sys_rst_in,
  .osc_in, .osc_cascade_out, .dte_send_pair_in, .dte_send_pair_active_in, .mau_send_pair_out,
  .mau_col_pair_in, .dte_col_pair_out, .quality_test_enable_n_in, .cascade_send_active_in,
  .cascade_col_in, .cascade_col_out, .babble_lamp_port1_n_out, .send_lamp_port2_n_out);
`default_nettype wire

// >>> dv/amux_far_end.sv
// far-side model: reference oscillator, transceiver and pulled-up loop strap
`timescale 1ns/1ps
`default_nettype none
module amux_far_end (
  input wire logic clock_in,
  input wire logic recv_go_in,
  input wire logic col_go_in,
  input wire logic strap_low_in,
  input wire logic lamp_oe_in,
  output logic osc_out,
  output logic recv_data_out,
  output logic recv_active_out,
  output logic col_out,
  output logic pin_out
);
  logic osc_q = 1'b0;
  logic pat_q = 1'b0;
  // odd offset keeps reference edges clear of the bench clock edges
  initial begin
    #1;
    forever #50 osc_q = ~osc_q;
  end
  always @(posedge clock_in) pat_q <= ~pat_q;
  assign osc_out = osc_q;
  assign recv_data_out = pat_q;
  assign recv_active_out = recv_go_in;
  assign col_out = col_go_in;
  assign pin_out = !(strap_low_in || lamp_oe_in);
endmodule
`default_nettype wire

// >>> dv/amux_top_tb.sv
// self-checking bench for the aui multiplexer control
`timescale 1ns/1ps
`default_nettype none
module amux_top_tb;
  import amux_pkg::*;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic osc_in, mau_recv_pair_in, mau_recv_pair_active_in, mau_col_pair_in;
  logic receive_lamp_loop_select_n_in, rx_go = 1'b0, col_go = 1'b0, strap_low = 1'b0;
  logic [3:0] dte_send_pair_in = 4'h0, dte_send_pair_active_in = 4'h0;
  logic [3:0] quality_test_enable_n_in = 4'hf, s_axi_wstrb = 4'hf;
  logic cascade_send_active_in = 1'b0, cascade_col_in = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdv, resp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic osc_cascade_out, mau_send_pair_out, mau_send_pair_active_out, cascade_send_active_out;
  logic [3:0] dte_recv_pair_out, dte_recv_pair_active_out, dte_col_pair_out, seen, rx_s;
  logic cascade_col_out, contention_lamp_n_out, receive_lamp_loop_select_n_out, col_s, act_s;
  logic babble_lamp_port1_n_out, babble_lamp_port2_n_out, babble_lamp_port3_n_out;
  logic babble_lamp_port4_n_out, send_lamp_port1_n_out, send_lamp_port2_n_out;
  logic send_lamp_port3_n_out, send_lamp_port4_n_out, receive_lamp_loop_select_n_oe_out;
  logic irq_out, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int tg;
  int n_errors = 0;
  int compares = 0;
  wire logic [9:0] lamps_n = {contention_lamp_n_out, babble_lamp_port1_n_out,
    babble_lamp_port2_n_out, babble_lamp_port3_n_out, babble_lamp_port4_n_out,
    send_lamp_port1_n_out, send_lamp_port2_n_out, send_lamp_port3_n_out,
    send_lamp_port4_n_out, !receive_lamp_loop_select_n_oe_out};
  always #4 clock_in = ~clock_in;
  amux_top #(.JABBER_TICKS(20), .LAMP_TICKS(5)) amux_top_i (.*);
  amux_far_end amux_far_end_i (.clock_in(clock_in), .recv_go_in(rx_go), .col_go_in(col_go),
    .strap_low_in(strap_low), .lamp_oe_in(receive_lamp_loop_select_n_oe_out), .osc_out(osc_in),
    .recv_data_out(mau_recv_pair_in), .recv_active_out(mau_recv_pair_active_in),
    .col_out(mau_col_pair_in), .pin_out(receive_lamp_loop_select_n_in));
  task complete_run;
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clock_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clock_in);
      ad = ad || s_axi_awready;
      wd = wd || s_axi_wready;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid) @(posedge clock_in);
    resp = {30'h0, s_axi_bresp};
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock_in); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock_in); while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    resp = {30'h0, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // ports in m send toggling data for n cycles; collisions and mau_send_pair_out edges are gathered
  task run(input logic [3:0] m, input int n);
    logic last;
    seen = 4'h0;
    tg = 0;
    last = mau_send_pair_out;
    dte_send_pair_active_in <= m;
    repeat (n) begin
      @(posedge clock_in);
      seen = seen | dte_col_pair_out;
      tg = tg + int'(mau_send_pair_out != last);
      last = mau_send_pair_out;
      dte_send_pair_in <= (dte_send_pair_in ^ m) & m;
    end
    col_s = cascade_col_out;
    rx_s = dte_recv_pair_active_out;
    act_s = mau_send_pair_active_out;
  endtask
  initial begin
    repeat (5) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    chk("lamps", lamps_n, 32'h3ff);
    rd(OFF_STATE);
    chk("state", rdv, 32'h0);
    wr(OFF_MASK, 32'h3f);
    rd(OFF_MASK);
    chk("mask", rdv, 32'h3f);
    rd(8'h10);
    chk("rresp", resp, 32'h2);
    wr(8'h14, 32'h1);
    chk("bresp", resp, 32'h2);
    quality_test_enable_n_in <= 4'he;
    run(4'h1, 40);
    chk("mau active", act_s, 1'b1);
    chk("cascade send", cascade_send_active_out, 1'b1);
    run(4'h0, 350);
    chk("sqe", seen, 4'h1);
    quality_test_enable_n_in <= 4'hf;
    run(4'h1, 40);
    run(4'h0, 350);
    chk("sqe off", seen, 4'h0);
    run(4'h3, 100);
    chk("multi", col_s, 1'b1);
    chk("col all", seen, 4'hf);
    chk("jam", tg > 3, 1'b1);
    chk("lamps busy", lamps_n, 32'h1e7);
    run(4'h0, 5);
    chk("irq", irq_out, 1'b1);
    rd(OFF_STATUS);
    chk("status", rdv, 32'h1);
    wr(OFF_STATUS, 32'h1);
    chk("irq clear", irq_out, 1'b0);
    wr(OFF_MASK, 32'h0);
    col_go <= 1'b1;
    run(4'h0, 30);
    chk("mau col", seen, 4'hf);
    chk("irq masked", irq_out, 1'b0);
    col_go <= 1'b0;
    wr(OFF_MASK, 32'h3f);
    chk("irq unmasked", irq_out, 1'b1);
    wr(OFF_STATUS, 32'h3f);
    chk("irq cleared", irq_out, 1'b0);
    cascade_col_in <= 1'b1;
    run(4'h0, 30);
    chk("cascade col", seen, 4'hf);
    cascade_col_in <= 1'b0;
    cascade_send_active_in <= 1'b1;
    run(4'h1, 10);
    chk("cascade overlap", col_s, 1'b1);
    cascade_send_active_in <= 1'b0;
    run(4'h0, 5);
    quality_test_enable_n_in <= 4'he;
    run(4'h1, 320);
    chk("jabber lamp", babble_lamp_port1_n_out, 1'b0);
    chk("jabber col", seen, 4'h1);
    rd(OFF_STATE);
    chk("jabber state", rdv[7:4], 4'h1);
    run(4'h0, 5);
    run(4'h0, 345);
    chk("jabber off", babble_lamp_port1_n_out, 1'b1);
    chk("no sqe", seen, 4'h0);
    rx_go <= 1'b1;
    run(4'h0, 20);
    chk("broadcast", rx_s, 4'hf);
    chk("rx data", dte_recv_pair_out, {4{!mau_recv_pair_in}});
    chk("rx pin", receive_lamp_loop_select_n_out, 1'b0);
    chk("rx lamp", receive_lamp_loop_select_n_oe_out, 1'b1);
    rx_go <= 1'b0;
    run(4'h0, 20);
    chk("rx stretch", receive_lamp_loop_select_n_oe_out, 1'b1);
    run(4'h0, 100);
    chk("rx lamp off", receive_lamp_loop_select_n_oe_out, 1'b0);
    wr(OFF_CTRL, 32'h42);
    run(4'h4, 20);
    chk("port off", act_s, 1'b0);
    rd(OFF_STATE);
    chk("loop force", rdv, 32'h100);
    run(4'h0, 5);
    wr(OFF_CTRL, 32'h0);
    strap_low <= 1'b1;
    run(4'h2, 20);
    chk("loopback", rx_s, 4'hf);
    strap_low <= 1'b0;
    run(4'h0, 5);
    complete_run();
  end
  initial begin
    #100_000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
